// [verilog/fam_pkg.sv]
package fam_pkg;

  // ----------------------------------------------------------------
  // Request and answer carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic refmode;
    logic [7:0] func;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fam_req_s;

  typedef struct packed {
    logic valid;
    logic exc;
    logic [15:0] rdata;
  } fam_rsp_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOOK = 3'b010,
    ST_ANSW = 3'b100
  } fam_state_e;

  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INP = 8'h04;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;

  // ----------------------------------------------------------------
  // Slots
  // ----------------------------------------------------------------
  localparam logic [5:0] SLOT_FIRST_IO = 6'h01;
  localparam logic [5:0] SLOT_LAST_IO = 6'h30;
  localparam logic [5:0] SLOT_GW_A = 6'h00;
  localparam logic [5:0] SLOT_GW_B = 6'h31;
  localparam logic [5:0] SLOT_PSU = 6'h32;
  localparam int NSLOT = 51;
  localparam int NIMG = 16;

  // ----------------------------------------------------------------
  // Direct holding map
  // ----------------------------------------------------------------
  localparam logic [15:0] H_ALLOC_AO = 16'h0000;
  localparam logic [15:0] H_SINGLE = 16'h0100;
  localparam logic [15:0] H_DBL12 = 16'h0200;
  localparam logic [15:0] H_DBL34 = 16'h0280;
  localparam logic [15:0] H_CMD = 16'h0300;
  localparam logic [15:0] H_DI_IMG = 16'h0400;
  localparam logic [15:0] H_DO_IMG = 16'h0500;
  localparam logic [15:0] H_AI_IMG = 16'h0600;

  // ----------------------------------------------------------------
  // Direct input map
  // ----------------------------------------------------------------
  localparam logic [15:0] I_ALLOC_AI = 16'h0000;
  localparam logic [15:0] I_SINGLE = 16'h0100;
  localparam logic [15:0] I_DBL12 = 16'h0200;
  localparam logic [15:0] I_DBL34 = 16'h0280;
  localparam logic [15:0] I_STATUS = 16'h0300;
  localparam logic [15:0] I_TYPE = 16'h0400;
  localparam logic [15:0] I_RED = 16'h0600;
  localparam logic [15:0] I_PRED = 16'h0700;
  localparam logic [15:0] I_AUX = 16'h0800;

  // ----------------------------------------------------------------
  // Reference-number map (inputs)
  // ----------------------------------------------------------------
  localparam logic [15:0] R_ALLOC_AI = 16'h7531;
  localparam logic [15:0] R_SINGLE = 16'h88b8;
  localparam logic [15:0] R_DBL12 = 16'h891c;
  localparam logic [15:0] R_STATUS = 16'h8980;
  localparam logic [15:0] R_TYPE = 16'h89e4;
  localparam logic [15:0] R_DBL34 = 16'h8a48;
  localparam logic [15:0] R_RED = 16'h8aac;
  localparam logic [15:0] R_PRED = 16'h8b10;
  localparam logic [15:0] R_AUX = 16'h8b74;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam logic [15:0] RED_WORDS = 16'h0008;
  localparam logic [15:0] AUX_WORDS = 16'h000c;
  localparam logic [15:0] IMG_WORDS = 16'h0010;
  localparam logic [15:0] ALLOC_WORDS = 16'h0010;
  localparam logic [15:0] DBL_SPAN = 16'h0064;

endpackage

// [verilog/fam_address_map.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Direct holding area: read with code 3, write with 6 or 16.
// - Reference mode picks the area from address range, ignoring function.
// - Slots 0 and 49 gateways, 50 supply, 1 to 48 I/O modules.
// - Single-word outputs at 256 plus slot, slots 1 to 48.
// - Two-word outputs: ch1-2 at 512+2*slot, ch3-4 at 640+2*slot.
// - Reference single-word inputs or output status at 35000 plus slot.
// - Reference two-word inputs: 35100+2*slot and 35400+2*slot.
// - Frequency/12-bit counter in one-word range; 32-bit in two-word.
// - Field aux variables: twelve words per slot at 35700+12*slot.
// - Aux variables supplied only when protocol and scan enables active.
// - New parameter set invalidates aux until a fresh scan completes.
// - Aux words may refresh slower than process words.
// - Command word at holding 768, readable and writable.
// - Packed digital input image at 1024, writes refused.
// - Packed digital output image at 1280, readable and writable.
// - Packed images go word by word, sixteen bits per address step.
// - Mirrored analog input image at 1536, writes refused.
// - Redundancy states: local eight words 35500, peer eight at 35600.
// - Reference allocated analog input image starts at 30001.
// - Command word: parameter byte first (high), command byte second.
// - A command runs only when the command word changes.
module fam_address_map (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Request from protocol engine
  input wire fam_pkg::fam_req_s i_req,
  output fam_pkg::fam_rsp_s o_rsp,
  // Process inputs from the station
  input wire logic [50:0][15:0] i_ai_word,
  input wire logic [50:0][15:0] i_ai_ch12,
  input wire logic [50:0][15:0] i_ai_ch34,
  input wire logic [50:0][15:0] i_slot_status,
  input wire logic [50:0][15:0] i_slot_type,
  input wire logic [50:0] i_slot_present,
  input wire logic [7:0][15:0] i_red_local,
  input wire logic [7:0][15:0] i_red_peer,
  input wire logic [255:0] i_di_image,
  input wire logic [15:0][15:0] i_ai_alloc,
  // Field aux variables, one word per write strobe
  input wire logic [50:0] i_field_protocol_enable,
  input wire logic [50:0] i_scan_enable,
  input wire logic i_param_new,
  input wire logic i_aux_we,
  input wire logic [5:0] i_aux_slot,
  input wire logic [3:0] i_aux_idx,
  input wire logic [15:0] i_aux_data,
  input wire logic i_aux_scan_done,
  // Outputs to the station
  output logic [50:0][15:0] o_ao_word,
  output logic [50:0][15:0] o_ao_ch12,
  output logic [50:0][15:0] o_ao_ch34,
  output logic [15:0][15:0] o_ao_alloc,
  output logic [255:0] o_do_image,
  output logic [7:0] o_cmd_param,
  output logic [7:0] o_cmd_code,
  output logic o_cmd_exec
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fam_pkg::fam_state_e st;
    fam_pkg::fam_req_s req;
    fam_pkg::fam_rsp_s rsp;
    logic [50:0][15:0] ao_word;
    logic [50:0][15:0] ao_ch12;
    logic [50:0][15:0] ao_ch34;
    logic [15:0][15:0] ao_alloc;
    logic [255:0] do_img;
    logic [15:0] cmd;
    logic [15:0] cmd_prev;
    logic cmd_exec;
    logic [50:0] aux_valid;
  } fam_state_s;

  fam_state_s s_q;
  fam_state_s s_d;

  // Aux store is large, kept apart from the packed state
  logic [15:0] aux_mem_q [0:611];

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_rng(input logic [15:0] a,
                                  input logic [15:0] base,
                                  input logic [15:0] len);
    in_rng = (a >= base) && (a < base + len);
  endfunction

  function automatic logic io_slot(input logic [5:0] sl);
    io_slot = (sl >= fam_pkg::SLOT_FIRST_IO) &&
              (sl <= fam_pkg::SLOT_LAST_IO);
  endfunction

  logic [15:0] a;
  logic ref_m;
  logic rd_hold;
  logic wr_hold;
  logic rd_inp;
  logic [15:0] off;
  logic [5:0] sl;
  logic [9:0] aux_i;
  logic exc;
  logic [15:0] rd;
  logic wr_ok;

  assign a = s_q.req.addr;
  assign ref_m = s_q.req.refmode;

  always_comb begin
    rd_hold = 1'b0;
    wr_hold = 1'b0;
    rd_inp = 1'b0;
    if (!ref_m) begin
      rd_hold = s_q.req.func == fam_pkg::FC_READ_HOLD;
      wr_hold = (s_q.req.func == fam_pkg::FC_WRITE_ONE) ||
                (s_q.req.func == fam_pkg::FC_WRITE_MANY);
      rd_inp = s_q.req.func == fam_pkg::FC_READ_INP;
    end else begin
      // Area from range only; write bit just says direction
      rd_inp = !s_q.req.write;
    end
  end

  // ----------------------------------------------------------------
  // Address decode and read mux
  // ----------------------------------------------------------------
  always_comb begin
    exc = 1'b1;
    rd = 16'h0000;
    wr_ok = 1'b0;
    off = 16'h0000;
    sl = 6'h00;
    aux_i = 10'h000;
    if (rd_hold || wr_hold) begin
      if (in_rng(a, fam_pkg::H_ALLOC_AO, fam_pkg::ALLOC_WORDS)) begin
        off = a - fam_pkg::H_ALLOC_AO;
        exc = 1'b0;
        wr_ok = wr_hold;
        rd = s_q.ao_alloc[off[3:0]];
      end else if (in_rng(a, fam_pkg::H_SINGLE, 16'h0033)) begin
        sl = 6'(a - fam_pkg::H_SINGLE);
        exc = 1'b0;
        wr_ok = wr_hold && io_slot(sl);
        rd = io_slot(sl) ? s_q.ao_word[sl] : 16'h0000;
      end else if (in_rng(a, fam_pkg::H_DBL12, 16'h0062)) begin
        off = a - fam_pkg::H_DBL12;
        sl = off[6:1];
        exc = 1'b0;
        wr_ok = wr_hold && io_slot(sl) && !off[0];
        rd = (io_slot(sl) && !off[0]) ? s_q.ao_ch12[sl] : 16'h0000;
      end else if (in_rng(a, fam_pkg::H_DBL34, 16'h0062)) begin
        off = a - fam_pkg::H_DBL34;
        sl = off[6:1];
        exc = 1'b0;
        wr_ok = wr_hold && io_slot(sl) && !off[0];
        rd = (io_slot(sl) && !off[0]) ? s_q.ao_ch34[sl] : 16'h0000;
      end else if (a == fam_pkg::H_CMD) begin
        exc = 1'b0;
        wr_ok = wr_hold;
        rd = s_q.cmd;
      end else if (in_rng(a, fam_pkg::H_DI_IMG, fam_pkg::IMG_WORDS)) begin
        off = a - fam_pkg::H_DI_IMG;
        exc = wr_hold;
        rd = i_di_image[off[3:0]*16 +: 16];
      end else if (in_rng(a, fam_pkg::H_DO_IMG, fam_pkg::IMG_WORDS)) begin
        off = a - fam_pkg::H_DO_IMG;
        exc = 1'b0;
        wr_ok = wr_hold;
        rd = s_q.do_img[off[3:0]*16 +: 16];
      end else if (in_rng(a, fam_pkg::H_AI_IMG, fam_pkg::ALLOC_WORDS)) begin
        off = a - fam_pkg::H_AI_IMG;
        exc = wr_hold;
        rd = i_ai_alloc[off[3:0]];
      end
    end else if (rd_inp) begin
      // Direct and reference input maps share one slot layout
      if (in_rng(a, ref_m ? fam_pkg::R_ALLOC_AI : fam_pkg::I_ALLOC_AI,
                 fam_pkg::ALLOC_WORDS)) begin
        off = a - (ref_m ? fam_pkg::R_ALLOC_AI : fam_pkg::I_ALLOC_AI);
        exc = 1'b0;
        rd = i_ai_alloc[off[3:0]];
      end else if (in_rng(a, ref_m ? fam_pkg::R_SINGLE : fam_pkg::I_SINGLE,
                          16'h0033)) begin
        sl = 6'(a - (ref_m ? fam_pkg::R_SINGLE : fam_pkg::I_SINGLE));
        exc = 1'b0;
        rd = (io_slot(sl) && i_slot_present[sl]) ? i_ai_word[sl] : 16'h0000;
      end else if (in_rng(a, ref_m ? fam_pkg::R_DBL12 : fam_pkg::I_DBL12,
                          16'h0062)) begin
        // Span ends at slot 48; wider would shadow status slot 0
        off = a - (ref_m ? fam_pkg::R_DBL12 : fam_pkg::I_DBL12);
        sl = off[6:1];
        exc = 1'b0;
        rd = (io_slot(sl) && !off[0] && i_slot_present[sl]) ?
             i_ai_ch12[sl] : 16'h0000;
      end else if (in_rng(a, ref_m ? fam_pkg::R_DBL34 : fam_pkg::I_DBL34,
                          16'h0062)) begin
        // Span ends at slot 48; wider would shadow redundancy words
        off = a - (ref_m ? fam_pkg::R_DBL34 : fam_pkg::I_DBL34);
        sl = off[6:1];
        exc = 1'b0;
        rd = (io_slot(sl) && !off[0] && i_slot_present[sl]) ?
             i_ai_ch34[sl] : 16'h0000;
      end else if (in_rng(a, ref_m ? fam_pkg::R_STATUS : fam_pkg::I_STATUS,
                          16'h0033)) begin
        sl = 6'(a - (ref_m ? fam_pkg::R_STATUS : fam_pkg::I_STATUS));
        exc = 1'b0;
        rd = i_slot_status[sl];
      end else if (in_rng(a, ref_m ? fam_pkg::R_TYPE : fam_pkg::I_TYPE,
                          16'h0033)) begin
        sl = 6'(a - (ref_m ? fam_pkg::R_TYPE : fam_pkg::I_TYPE));
        exc = 1'b0;
        rd = io_slot(sl) ? i_slot_type[sl] : 16'h0000;
      end else if (in_rng(a, ref_m ? fam_pkg::R_RED : fam_pkg::I_RED,
                          fam_pkg::RED_WORDS)) begin
        off = a - (ref_m ? fam_pkg::R_RED : fam_pkg::I_RED);
        exc = 1'b0;
        rd = i_red_local[off[2:0]];
      end else if (in_rng(a, ref_m ? fam_pkg::R_PRED : fam_pkg::I_PRED,
                          fam_pkg::RED_WORDS)) begin
        off = a - (ref_m ? fam_pkg::R_PRED : fam_pkg::I_PRED);
        exc = 1'b0;
        rd = i_red_peer[off[2:0]];
      end else if (in_rng(a, ref_m ? fam_pkg::R_AUX : fam_pkg::I_AUX,
                          16'h0264)) begin
        off = a - (ref_m ? fam_pkg::R_AUX : fam_pkg::I_AUX);
        aux_i = off[9:0];
        sl = 6'(off / fam_pkg::AUX_WORDS);
        exc = 1'b0;
        rd = (io_slot(sl) && s_q.aux_valid[sl] &&
              i_field_protocol_enable[sl] && i_scan_enable[sl]) ?
             aux_mem_q[aux_i] : 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rsp.valid = 1'b0;
    s_d.cmd_exec = 1'b0;
    case (s_q.st)
      fam_pkg::ST_IDLE: begin
        if (i_req.valid) begin
          s_d.req = i_req;
          s_d.st = fam_pkg::ST_LOOK;
        end
      end
      fam_pkg::ST_LOOK: begin
        s_d.rsp.valid = 1'b1;
        s_d.rsp.exc = exc;
        s_d.rsp.rdata = (exc || wr_hold) ? 16'h0000 : rd;
        if (!exc && wr_ok) begin
          if (a == fam_pkg::H_CMD)
            s_d.cmd = s_q.req.wdata;
          else if (in_rng(a, fam_pkg::H_ALLOC_AO, fam_pkg::ALLOC_WORDS))
            s_d.ao_alloc[off[3:0]] = s_q.req.wdata;
          else if (in_rng(a, fam_pkg::H_SINGLE, 16'h0033))
            s_d.ao_word[sl] = s_q.req.wdata;
          else if (in_rng(a, fam_pkg::H_DBL12, 16'h0062))
            s_d.ao_ch12[sl] = s_q.req.wdata;
          else if (in_rng(a, fam_pkg::H_DBL34, 16'h0062))
            s_d.ao_ch34[sl] = s_q.req.wdata;
          else
            s_d.do_img[off[3:0]*16 +: 16] = s_q.req.wdata;
        end
        s_d.st = fam_pkg::ST_ANSW;
      end
      fam_pkg::ST_ANSW: begin
        s_d.st = fam_pkg::ST_IDLE;
      end
      default: begin
        s_d.st = fam_pkg::ST_IDLE;
      end
    endcase
    // Edge on a changed word fires one execution
    if (s_q.cmd != s_q.cmd_prev) begin
      s_d.cmd_exec = 1'b1;
      s_d.cmd_prev = s_q.cmd;
    end
    // Scan done after a new set revalidates; new set wins same cycle
    if (i_aux_scan_done)
      s_d.aux_valid = {fam_pkg::NSLOT{1'b1}};
    if (i_param_new)
      s_d.aux_valid = '0;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_q <= '{st: fam_pkg::ST_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Aux words land at their own pace, independent of the cycle
  always_ff @(posedge i_clk) begin
    if (i_aux_we && io_slot(i_aux_slot)) begin
      aux_mem_q[10'(i_aux_slot * 12 + i_aux_idx)] <= i_aux_data;
    end
  end

  assign o_rsp = s_q.rsp;
  assign o_ao_word = s_q.ao_word;
  assign o_ao_ch12 = s_q.ao_ch12;
  assign o_ao_ch34 = s_q.ao_ch34;
  assign o_ao_alloc = s_q.ao_alloc;
  assign o_do_image = s_q.do_img;
  assign o_cmd_param = s_q.cmd[15:8];
  assign o_cmd_code = s_q.cmd[7:0];
  assign o_cmd_exec = s_q.cmd_exec;

endmodule // fam_address_map

// [dv/fam_address_map_chk.sv]
`timescale 1ns/1ps
module fam_address_map_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Watched ports
  input wire fam_pkg::fam_req_s i_req,
  input wire fam_pkg::fam_rsp_s o_rsp,
  input wire logic [7:0] o_cmd_param,
  input wire logic [7:0] o_cmd_code,
  input wire logic o_cmd_exec
);
  // ----------------------------------------------------------------
  // Request tracking
  // ----------------------------------------------------------------
  logic [1:0] busy_q;
  logic taken;
  logic hold_rd;
  assign taken = i_req.valid && (busy_q == 2'h0);
  assign hold_rd = taken && !i_req.refmode && (i_req.func == 8'h03);
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 2'h0;
    end else if (taken) begin
      busy_q <= 2'h2;
    end else if (busy_q != 2'h0) begin
      busy_q <= busy_q - 2'h1;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  rsp_on_time_a: assert property (taken |-> ##2 o_rsp.valid)
    else $error("answer late or missing");
  rsp_cause_a: assert property (o_rsp.valid |-> $past(taken, 2))
    else $error("answer without request");
  ro_write_a: assert property (taken && !i_req.refmode &&
    (i_req.func == 8'h06) && ((i_req.addr[15:4] == 12'h040) ||
    (i_req.addr[15:4] == 12'h060)) |-> ##2 o_rsp.exc)
    else $error("write to read-only image accepted");
  ref_any_func_a: assert property (taken && i_req.refmode &&
    !i_req.write && (i_req.addr >= 16'h88b9) && (i_req.addr <= 16'h88e8)
    |-> ##2 !o_rsp.exc)
    else $error("reference read refused");
  odd_word_zero_a: assert property (hold_rd && i_req.addr[0] &&
    (i_req.addr >= 16'h0201) && (i_req.addr <= 16'h0261)
    |-> ##2 (o_rsp.rdata == 16'h0000) && !o_rsp.exc)
    else $error("odd two-word offset not zero");
  unmapped_a: assert property (hold_rd &&
    (i_req.addr[15:8] == 8'h07) |-> ##2 o_rsp.exc)
    else $error("unmapped address accepted");
  bad_func_a: assert property (taken && !i_req.refmode &&
    !(i_req.func inside {8'h03, 8'h04, 8'h06, 8'h10}) |-> ##2 o_rsp.exc)
    else $error("unknown function accepted");
  exec_cause_a: assert property (o_cmd_exec |->
    $past({o_cmd_param, o_cmd_code}) != $past({o_cmd_param, o_cmd_code}, 2))
    else $error("command run without change");
  exec_due_a: assert property ($changed({o_cmd_param, o_cmd_code})
    |=> o_cmd_exec)
    else $error("changed command not run");
  exec_pulse_a: assert property (o_cmd_exec |=> !o_cmd_exec)
    else $error("command run twice");
endmodule // fam_address_map_chk

bind fam_address_map fam_address_map_chk u_chk (
  .i_clk(i_clk),
  .i_nrst(i_nrst),
  .i_req(i_req),
  .o_rsp(o_rsp),
  .o_cmd_param(o_cmd_param),
  .o_cmd_code(o_cmd_code),
  .o_cmd_exec(o_cmd_exec)
);

// [dv/fam_modbus_master.sv]
`timescale 1ns/1ps
module fam_modbus_master (
  // Clock
  input wire logic i_clk,
  // Request and answer
  output fam_pkg::fam_req_s o_req,
  input wire fam_pkg::fam_rsp_s i_rsp
);
  initial o_req = '0;
  // One word per request; released addr and wdata go inverted, never stale
  task automatic xfer(input logic m, input logic [7:0] f, input logic w,
    input logic [15:0] a, input logic [15:0] d,
    output fam_pkg::fam_rsp_s r);
    int n;
    @(negedge i_clk);
    o_req <= '{valid:1'b1, refmode:m, func:f, write:w, addr:a, wdata:d};
    @(posedge i_clk);
    @(negedge i_clk);
    o_req.valid <= 1'b0;
    o_req.addr <= ~a;
    o_req.wdata <= ~d;
    // Answer is looked at mid-cycle, never in its launching time step
    for (n = 0; n < 4; n++) begin
      @(negedge i_clk);
      if (i_rsp.valid) break;
    end
    r = i_rsp;
  endtask
endmodule // fam_modbus_master

// [dv/fam_address_map_tb.sv]
`timescale 1ns/1ps
module fam_address_map_tb;
  logic clk, nrst, pnew, awe, sdone, cexec;
  logic [50:0][15:0] aw, a12, a34, st, ty, ow, o12, o34;
  logic [50:0] pres, hen, sen;
  logic [7:0][15:0] rl, rp;
  logic [15:0][15:0] aia, oalloc;
  logic [255:0] di, dimg;
  logic [5:0] aslot;
  logic [3:0] aidx;
  logic [15:0] adata;
  logic [7:0] cpar, ccod;
  fam_pkg::fam_req_s req;
  fam_pkg::fam_rsp_s rsp;
  int num_errors = 0;
  int tests_run = 0;
  fam_address_map u_dut (.i_clk(clk), .i_nrst(nrst), .i_req(req),
    .o_rsp(rsp), .i_ai_word(aw), .i_ai_ch12(a12), .i_ai_ch34(a34),
    .i_slot_status(st), .i_slot_type(ty), .i_slot_present(pres),
    .i_red_local(rl), .i_red_peer(rp), .i_di_image(di), .i_ai_alloc(aia),
    .i_field_protocol_enable(hen), .i_scan_enable(sen), .i_param_new(pnew),
    .i_aux_we(awe), .i_aux_slot(aslot), .i_aux_idx(aidx),
    .i_aux_data(adata), .i_aux_scan_done(sdone), .o_ao_word(ow),
    .o_ao_ch12(o12), .o_ao_ch34(o34), .o_ao_alloc(oalloc),
    .o_do_image(dimg), .o_cmd_param(cpar), .o_cmd_code(ccod),
    .o_cmd_exec(cexec));
  fam_modbus_master u_mst (.i_clk(clk), .o_req(req), .i_rsp(rsp));
  always #20 clk = ~clk;
  // ----------------------------------------------------------------
  // Compare and access helpers
  // ----------------------------------------------------------------
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic op(input logic m, input logic [7:0] f, input logic w,
    input logic [15:0] a, input logic [15:0] d, input logic ex,
    input logic [15:0] e);
    fam_pkg::fam_rsp_s r;
    u_mst.xfer(m, f, w, a, d, r);
    cmp1(r.valid, 1'b1);
    cmp1(r.exc, ex);
    if (!ex) cmp16(r.rdata, e);
  endtask
  task automatic pulse(input int k);
    @(negedge clk);
    if (k == 0) awe = 1'b1;
    if (k == 1) sdone = 1'b1;
    if (k == 2) pnew = 1'b1;
    @(negedge clk);
    awe = 1'b0;
    sdone = 1'b0;
    pnew = 1'b0;
  endtask
  task automatic stop_test;
    $display("errors=%0d comparisons=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_outputs;
    op(1'b0, 8'h06, 1'b0, 16'h0101, 16'h1111, 1'b0, 16'h0000);
    cmp16(ow[1], 16'h1111);
    op(1'b0, 8'h10, 1'b0, 16'h0130, 16'h2222, 1'b0, 16'h0000);
    cmp16(ow[48], 16'h2222);
    op(1'b0, 8'h10, 1'b0, 16'h020a, 16'h3333, 1'b0, 16'h0000);
    cmp16(o12[5], 16'h3333);
    op(1'b0, 8'h06, 1'b0, 16'h02e0, 16'h4444, 1'b0, 16'h0000);
    cmp16(o34[48], 16'h4444);
    op(1'b0, 8'h03, 1'b0, 16'h0101, 16'h0000, 1'b0, 16'h1111);
    op(1'b0, 8'h03, 1'b0, 16'h020b, 16'h0000, 1'b0, 16'h0000);
  endtask
  task automatic t_cmd;
    op(1'b0, 8'h06, 1'b0, 16'h0300, 16'habcd, 1'b0, 16'h0000);
    @(negedge clk);
    cmp1(cexec, 1'b1);
    cmp16({cpar, ccod}, 16'habcd);
    @(negedge clk);
    cmp1(cexec, 1'b0);
    op(1'b0, 8'h10, 1'b0, 16'h0300, 16'habcd, 1'b0, 16'h0000);
    @(negedge clk);
    cmp1(cexec, 1'b0);
    op(1'b0, 8'h03, 1'b0, 16'h0300, 16'h0000, 1'b0, 16'habcd);
  endtask
  task automatic t_images;
    op(1'b0, 8'h03, 1'b0, 16'h0401, 16'h0000, 1'b0, 16'h9001);
    op(1'b0, 8'h06, 1'b0, 16'h0401, 16'h1234, 1'b1, 16'h0000);
    op(1'b0, 8'h10, 1'b0, 16'h0502, 16'h5a5a, 1'b0, 16'h0000);
    cmp16(dimg[47:32], 16'h5a5a);
    op(1'b0, 8'h03, 1'b0, 16'h0502, 16'h0000, 1'b0, 16'h5a5a);
    op(1'b0, 8'h03, 1'b0, 16'h0603, 16'h0000, 1'b0, 16'h8003);
    op(1'b0, 8'h10, 1'b0, 16'h0603, 16'h1234, 1'b1, 16'h0000);
  endtask
  task automatic t_ref;
    op(1'b1, 8'h03, 1'b0, 16'd35007, 16'h0000, 1'b0, 16'h1007);
    op(1'b1, 8'h04, 1'b0, 16'd35114, 16'h0000, 1'b0, 16'h2007);
    op(1'b1, 8'h00, 1'b0, 16'd35414, 16'h0000, 1'b0, 16'h3007);
    op(1'b1, 8'h03, 1'b0, 16'd35250, 16'h0000, 1'b0, 16'h4032);
    op(1'b1, 8'h03, 1'b0, 16'd35503, 16'h0000, 1'b0, 16'h6003);
    op(1'b1, 8'h03, 1'b0, 16'd35607, 16'h0000, 1'b0, 16'h7007);
    op(1'b1, 8'h03, 1'b0, 16'd35500, 16'h0000, 1'b0, 16'h6000);
    op(1'b1, 8'h03, 1'b0, 16'd35200, 16'h0000, 1'b0, 16'h4000);
    op(1'b1, 8'h06, 1'b0, 16'd30003, 16'h0000, 1'b0, 16'h8002);
    @(negedge clk);
    pres[7] = 1'b0;
    op(1'b1, 8'h03, 1'b0, 16'd35007, 16'h0000, 1'b0, 16'h0000);
  endtask
  task automatic t_aux;
    aslot = 6'h04;
    aidx = 4'hb;
    adata = 16'hbeef;
    pulse(0);
    pulse(1);
    op(1'b1, 8'h03, 1'b0, 16'd35759, 16'h0000, 1'b0, 16'hbeef);
    op(1'b0, 8'h04, 1'b0, 16'h083b, 16'h0000, 1'b0, 16'hbeef);
    hen[4] = 1'b0;
    op(1'b1, 8'h03, 1'b0, 16'd35759, 16'h0000, 1'b0, 16'h0000);
    hen[4] = 1'b1;
    pulse(2);
    op(1'b1, 8'h03, 1'b0, 16'd35759, 16'h0000, 1'b0, 16'h0000);
    pulse(1);
    op(1'b1, 8'h03, 1'b0, 16'd35759, 16'h0000, 1'b0, 16'hbeef);
  endtask
  task automatic t_errs;
    op(1'b0, 8'h03, 1'b0, 16'h0700, 16'h0000, 1'b1, 16'h0000);
    op(1'b0, 8'h03, 1'b0, 16'h0610, 16'h0000, 1'b1, 16'h0000);
    op(1'b0, 8'h01, 1'b0, 16'h0101, 16'h0000, 1'b1, 16'h0000);
    op(1'b1, 8'h06, 1'b1, 16'd35007, 16'h0000, 1'b1, 16'h0000);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    {pnew, awe, sdone, aslot, aidx, adata} = '0;
    {pres, hen, sen} = '1;
    for (int s = 0; s < 51; s++) begin
      aw[s] = 16'h1000 + 16'(s);
      a12[s] = 16'h2000 + 16'(s);
      a34[s] = 16'h3000 + 16'(s);
      st[s] = 16'h4000 + 16'(s);
      ty[s] = 16'h5000 + 16'(s);
    end
    for (int k = 0; k < 16; k++) begin
      rl[k % 8] = 16'h6000 + 16'(k % 8);
      rp[k % 8] = 16'h7000 + 16'(k % 8);
      aia[k] = 16'h8000 + 16'(k);
      di[16 * k +: 16] = 16'h9000 + 16'(k);
    end
    repeat (5) @(posedge clk);
    cmp16({cpar, ccod}, 16'h0000);
    cmp1(cexec, 1'b0);
    @(negedge clk);
    nrst = 1'b1;
    t_outputs();
    t_cmd();
    t_images();
    t_ref();
    t_aux();
    t_errs();
    stop_test();
  end
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule // fam_address_map_tb
